// File: rtl/dbg_write_pkg.sv
package dbg_write_pkg;

   // word indices on the register bus (byte address = 4 * index)
   localparam logic [3:0] IDX_CTRL = 4'h0;
   localparam logic [3:0] IDX_LEAF = 4'h1;
   localparam logic [3:0] IDX_SRC_LO = 4'h2;
   localparam logic [3:0] IDX_SRC_HI = 4'h3;
   localparam logic [3:0] IDX_TGT_LO = 4'h4;
   localparam logic [3:0] IDX_TGT_HI = 4'h5;
   localparam logic [3:0] IDX_MODE = 4'h6;
   localparam logic [3:0] IDX_PAGE = 4'h7;
   localparam logic [3:0] IDX_PF_ERR = 4'h8;
   localparam logic [3:0] IDX_ACC_LO = 4'h9;
   localparam logic [3:0] IDX_ACC_HI = 4'hA;
   localparam logic [3:0] IDX_FLAGS = 4'hB;
   localparam logic [3:0] IDX_FAULT = 4'hC;
   localparam logic [3:0] IDX_FAULT_ERR = 4'hD;
   localparam int OPND_LAST = 8;

   // control word fields
   localparam int CTRL_GO_BIT = 0;
   localparam int CTRL_BUSY_BIT = 0;
   localparam int CTRL_DONE_BIT = 1;

   // arithmetic flag positions in the flags word
   localparam int FLG_CF = 0;
   localparam int FLG_PF = 2;
   localparam int FLG_AF = 4;
   localparam int FLG_ZF = 6;
   localparam int FLG_SF = 7;
   localparam int FLG_OF = 11;

   localparam logic [31:0] LEAF_SEL = 32'h0000_0005;
   localparam logic [11:0] THREAD_CTRL_OFS_MASK = 12'hFF8;
   localparam int CANON_MSB = 47;

   // encodings below are plain defaults
   localparam logic [7:0] REGULAR_PAGE_TYPE = 8'h01;
   localparam logic [7:0] THREAD_CONTROL_PAGE_TYPE = 8'h02;
   localparam logic [7:0] SHADOW_STACK_FIRST_TYPE = 8'h03;
   localparam logic [7:0] SHADOW_STACK_REST_TYPE = 8'h04;
   localparam logic [11:0] THREAD_CTRL_FLAGS_OFS = 12'h008;
   localparam logic [31:0] PAGE_NOT_DEBUGGABLE_CODE = 32'h0000_0010;

   localparam logic [1:0] FK_NONE = 2'h0;
   localparam logic [1:0] FK_GP = 2'h1;
   localparam logic [1:0] FK_PF = 2'h2;

   localparam logic [7:0] BE_QWORD = 8'hFF;
   localparam logic [7:0] BE_DWORD = 8'h0F;

   typedef enum logic [1:0] {OUT_OK, OUT_NOTDBG, OUT_GP, OUT_PF} outcome_e;

   typedef struct packed {
      logic [27:0] rsvd;
      logic [1:0] current_privilege_level;
      logic cs_l;
      logic long_mode_active_flag;
   } mode_s;

   typedef struct packed {
      logic [8:0] rsvd_hi;
      logic [2:0] rwx;
      logic owner_debug;
      logic conflict;
      logic modified;
      logic pending;
      logic [7:0] ptype;
      logic [4:0] rsvd_lo;
      logic valid;
      logic xlat_fault;
      logic resident;
   } page_info_s;

   typedef struct packed {
      logic valid;
      logic [63:0] addr;
      logic [63:0] data;
      logic [7:0] be;
   } mem_wr_s;

endpackage : dbg_write_pkg

// File: rtl/debug_enclave_write.sv
`timescale 1ns/1ps
module debug_enclave_write (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output dbg_write_pkg::mem_wr_s mem_wr
);

   typedef enum logic {ST_IDLE, ST_CHECK} state_e;

   function automatic logic [31:0] merge_be(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0] be);
      logic [31:0] res;
      res = old_w;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[8*b +: 8] = new_w[8*b +: 8];
         end
      end
      return res;
   endfunction : merge_be

   state_e st_ff;
   logic wait_ff;
   logic [31:0] rdata_ff;
   logic [31:0] opnd_ff [1:dbg_write_pkg::OPND_LAST];
   logic done_ff;
   logic [63:0] acc_ff;
   logic [31:0] flags_ff;
   logic [1:0] fkind_ff;
   logic [31:0] ferr_ff;
   dbg_write_pkg::mem_wr_s wr_ff;

   logic req;
   logic commit_wr;
   logic go;
   logic [31:0] rd_word;
   logic [63:0] src;
   logic [63:0] tgt;
   dbg_write_pkg::mode_s mode;
   dbg_write_pkg::page_info_s page;
   logic mode64;
   logic canon_ok;
   logic misalign;
   logic type_ok;
   logic tc_ofs_bad;
   dbg_write_pkg::outcome_e outcome;

   assign req = avs_read | avs_write;
   assign commit_wr = avs_write & ~wait_ff;
   assign go = commit_wr && avs_address == dbg_write_pkg::IDX_CTRL
               && avs_byteenable[0]
               && avs_writedata[dbg_write_pkg::CTRL_GO_BIT];

   assign src = {opnd_ff[dbg_write_pkg::IDX_SRC_HI],
                 opnd_ff[dbg_write_pkg::IDX_SRC_LO]};
   assign tgt = {opnd_ff[dbg_write_pkg::IDX_TGT_HI],
                 opnd_ff[dbg_write_pkg::IDX_TGT_LO]};
   assign mode = dbg_write_pkg::mode_s'(opnd_ff[dbg_write_pkg::IDX_MODE]);
   assign page =
      dbg_write_pkg::page_info_s'(opnd_ff[dbg_write_pkg::IDX_PAGE]);

   assign mode64 = mode.long_mode_active_flag & mode.cs_l;
   assign canon_ok = (&tgt[63:dbg_write_pkg::CANON_MSB])
                     | ~(|tgt[63:dbg_write_pkg::CANON_MSB]);
   assign misalign = mode64 ? |tgt[2:0] : |tgt[1:0];
   // any other type, the control structure page among them, is refused
   assign type_ok = page.ptype == dbg_write_pkg::REGULAR_PAGE_TYPE
      || page.ptype == dbg_write_pkg::THREAD_CONTROL_PAGE_TYPE
      || page.ptype == dbg_write_pkg::SHADOW_STACK_FIRST_TYPE
      || page.ptype == dbg_write_pkg::SHADOW_STACK_REST_TYPE;
   assign tc_ofs_bad =
      page.ptype == dbg_write_pkg::THREAD_CONTROL_PAGE_TYPE
      && (tgt[11:0] & dbg_write_pkg::THREAD_CTRL_OFS_MASK)
         != (dbg_write_pkg::THREAD_CTRL_FLAGS_OFS
             & dbg_write_pkg::THREAD_CTRL_OFS_MASK);

   // first failing check decides; page.rwx is never consulted
   always_comb begin
      outcome = dbg_write_pkg::OUT_OK;
      if (opnd_ff[dbg_write_pkg::IDX_LEAF] != dbg_write_pkg::LEAF_SEL) begin
         outcome = dbg_write_pkg::OUT_GP;
      end else if (mode.current_privilege_level != 2'h0) begin
         outcome = dbg_write_pkg::OUT_GP;
      end else if (mode64 && !canon_ok) begin
         outcome = dbg_write_pkg::OUT_GP;
      end else if (misalign) begin
         outcome = dbg_write_pkg::OUT_GP;
      end else if (page.xlat_fault) begin
         outcome = dbg_write_pkg::OUT_PF;
      end else if (!page.resident) begin
         outcome = dbg_write_pkg::OUT_PF;
      end else if (page.conflict) begin
         outcome = dbg_write_pkg::OUT_GP;
      end else if (!page.valid) begin
         outcome = dbg_write_pkg::OUT_PF;
      end else if (!type_ok) begin
         outcome = dbg_write_pkg::OUT_PF;
      end else if (page.pending || page.modified) begin
         outcome = dbg_write_pkg::OUT_NOTDBG;
      end else if (tc_ofs_bad) begin
         outcome = dbg_write_pkg::OUT_GP;
      end else if (!page.owner_debug) begin
         outcome = dbg_write_pkg::OUT_GP;
      end
   end

   // one-cycle wait state, then the access completes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_ff <= 1'b1;
      end else begin
         wait_ff <= ~(req & wait_ff);
      end
   end

   always_comb begin
      rd_word = 32'h0000_0000;
      case (avs_address)
         dbg_write_pkg::IDX_CTRL: begin
            rd_word[dbg_write_pkg::CTRL_BUSY_BIT] = st_ff == ST_CHECK;
            rd_word[dbg_write_pkg::CTRL_DONE_BIT] = done_ff;
         end
         dbg_write_pkg::IDX_LEAF, dbg_write_pkg::IDX_SRC_LO,
         dbg_write_pkg::IDX_SRC_HI, dbg_write_pkg::IDX_TGT_LO,
         dbg_write_pkg::IDX_TGT_HI, dbg_write_pkg::IDX_MODE,
         dbg_write_pkg::IDX_PAGE, dbg_write_pkg::IDX_PF_ERR: begin
            rd_word = opnd_ff[avs_address];
         end
         dbg_write_pkg::IDX_ACC_LO: rd_word = acc_ff[31:0];
         dbg_write_pkg::IDX_ACC_HI: rd_word = acc_ff[63:32];
         dbg_write_pkg::IDX_FLAGS: rd_word = flags_ff;
         dbg_write_pkg::IDX_FAULT: rd_word = {30'h0, fkind_ff};
         dbg_write_pkg::IDX_FAULT_ERR: rd_word = ferr_ff;
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= 32'h0000_0000;
      end else if (avs_read && wait_ff) begin
         rdata_ff <= rd_word;
      end
   end

   // operand words; ignored while an operation is in flight
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 1; i <= dbg_write_pkg::OPND_LAST; i++) begin
            opnd_ff[i] <= 32'h0000_0000;
         end
      end else if (commit_wr && st_ff == ST_IDLE) begin
         for (int i = 1; i <= dbg_write_pkg::OPND_LAST; i++) begin
            if (avs_address == 4'(i)) begin
               opnd_ff[i] <= merge_be(opnd_ff[i], avs_writedata,
                                      avs_byteenable);
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= ST_IDLE;
      end else begin
         case (st_ff)
            ST_IDLE: if (go) st_ff <= ST_CHECK;
            ST_CHECK: st_ff <= ST_IDLE;
            default: st_ff <= ST_IDLE;
         endcase
      end
   end

   // completion wins over the clear by a new start
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done_ff <= 1'b0;
      end else if (st_ff == ST_CHECK) begin
         done_ff <= 1'b1;
      end else if (go) begin
         done_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_ff <= 64'h0000_0000_0000_0000;
         flags_ff <= 32'h0000_0000;
      end else if (st_ff == ST_CHECK) begin
         if (outcome == dbg_write_pkg::OUT_OK) begin
            acc_ff <= 64'h0000_0000_0000_0000;
            flags_ff[dbg_write_pkg::FLG_ZF] <= 1'b0;
         end else if (outcome == dbg_write_pkg::OUT_NOTDBG) begin
            acc_ff <= {32'h0000_0000,
                       dbg_write_pkg::PAGE_NOT_DEBUGGABLE_CODE};
            flags_ff[dbg_write_pkg::FLG_ZF] <= 1'b1;
         end
         if (outcome == dbg_write_pkg::OUT_OK
             || outcome == dbg_write_pkg::OUT_NOTDBG) begin
            flags_ff[dbg_write_pkg::FLG_CF] <= 1'b0;
            flags_ff[dbg_write_pkg::FLG_PF] <= 1'b0;
            flags_ff[dbg_write_pkg::FLG_AF] <= 1'b0;
            flags_ff[dbg_write_pkg::FLG_OF] <= 1'b0;
            flags_ff[dbg_write_pkg::FLG_SF] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fkind_ff <= dbg_write_pkg::FK_NONE;
         ferr_ff <= 32'h0000_0000;
      end else if (st_ff == ST_CHECK) begin
         case (outcome)
            dbg_write_pkg::OUT_GP: begin
               fkind_ff <= dbg_write_pkg::FK_GP;
               ferr_ff <= 32'h0000_0000;
            end
            dbg_write_pkg::OUT_PF: begin
               fkind_ff <= dbg_write_pkg::FK_PF;
               ferr_ff <= opnd_ff[dbg_write_pkg::IDX_PF_ERR];
            end
            default: begin
               fkind_ff <= dbg_write_pkg::FK_NONE;
               ferr_ff <= 32'h0000_0000;
            end
         endcase
      end
   end

   // memory store port, one-cycle strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ff <= '0;
      end else if (st_ff == ST_CHECK
                   && outcome == dbg_write_pkg::OUT_OK) begin
         wr_ff.valid <= 1'b1;
         wr_ff.addr <= tgt;
         if (mode64) begin
            wr_ff.data <= src;
            wr_ff.be <= dbg_write_pkg::BE_QWORD;
         end else begin
            wr_ff.data <= {32'h0000_0000, src[31:0]};
            wr_ff.be <= dbg_write_pkg::BE_DWORD;
         end
      end else begin
         wr_ff.valid <= 1'b0;
      end
   end

   assign avs_waitrequest = wait_ff;
   assign avs_readdata = rdata_ff;
   assign mem_wr = wr_ff;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_start;
      st_ff == ST_IDLE && go;
   endsequence
   sequence s_finish;
      st_ff == ST_CHECK ##1 st_ff == ST_IDLE && done_ff;
   endsequence

   property p_run;
      s_start |=> s_finish;
   endproperty
   a_run: assert property (p_run) else $error("run did not finish");

   property p_leaf;
      st_ff == ST_CHECK
         && opnd_ff[dbg_write_pkg::IDX_LEAF] != dbg_write_pkg::LEAF_SEL
         |=> fkind_ff == dbg_write_pkg::FK_GP && !wr_ff.valid;
   endproperty
   a_leaf: assert property (p_leaf) else $error("leaf not refused");

   property p_size;
      wr_ff.valid |-> wr_ff.be == ($past(mode.long_mode_active_flag)
         && $past(mode.cs_l) ? dbg_write_pkg::BE_QWORD
                             : dbg_write_pkg::BE_DWORD);
   endproperty
   a_size: assert property (p_size) else $error("write size wrong");

   property p_align;
      wr_ff.valid |-> (wr_ff.be == dbg_write_pkg::BE_QWORD
         ? wr_ff.addr[2:0] == 3'h0 : wr_ff.addr[1:0] == 2'h0);
   endproperty
   a_align: assert property (p_align) else $error("misaligned write");

   property p_gate;
      wr_ff.valid |-> $past(page.valid) && $past(page.resident)
         && $past(page.owner_debug) && !$past(page.conflict)
         && $past(mode.current_privilege_level) == 2'h0;
   endproperty
   a_gate: assert property (p_gate) else $error("write past check");

   property p_notdbg;
      st_ff == ST_CHECK && outcome == dbg_write_pkg::OUT_NOTDBG
         |=> flags_ff[dbg_write_pkg::FLG_ZF]
         && acc_ff[31:0] == dbg_write_pkg::PAGE_NOT_DEBUGGABLE_CODE
         && !wr_ff.valid;
   endproperty
   a_notdbg: assert property (p_notdbg) else $error("not debuggable");

   property p_success;
      wr_ff.valid |-> acc_ff == 64'h0000_0000_0000_0000
         && !flags_ff[dbg_write_pkg::FLG_ZF]
         && fkind_ff == dbg_write_pkg::FK_NONE;
   endproperty
   a_success: assert property (p_success) else $error("success bad");

   property p_flags;
      st_ff == ST_CHECK && (outcome == dbg_write_pkg::OUT_OK
         || outcome == dbg_write_pkg::OUT_NOTDBG)
         |=> !flags_ff[dbg_write_pkg::FLG_CF]
         && !flags_ff[dbg_write_pkg::FLG_PF]
         && !flags_ff[dbg_write_pkg::FLG_AF]
         && !flags_ff[dbg_write_pkg::FLG_OF]
         && !flags_ff[dbg_write_pkg::FLG_SF];
   endproperty
   a_flags: assert property (p_flags) else $error("flags not cleared");

   property p_data;
      wr_ff.valid |-> wr_ff.data[31:0] == $past(src[31:0]);
   endproperty
   a_data: assert property (p_data) else $error("write data wrong");

   property p_tcs;
      wr_ff.valid && $past(page.ptype)
         == dbg_write_pkg::THREAD_CONTROL_PAGE_TYPE
         |-> (wr_ff.addr[11:0] & dbg_write_pkg::THREAD_CTRL_OFS_MASK)
         == (dbg_write_pkg::THREAD_CTRL_FLAGS_OFS
             & dbg_write_pkg::THREAD_CTRL_OFS_MASK);
   endproperty
   a_tcs: assert property (p_tcs) else $error("offset not flags");

   property p_pf;
      st_ff == ST_CHECK && outcome == dbg_write_pkg::OUT_PF
         |=> fkind_ff == dbg_write_pkg::FK_PF
         && ferr_ff == $past(opnd_ff[dbg_write_pkg::IDX_PF_ERR]);
   endproperty
   a_pf: assert property (p_pf) else $error("page fault code wrong");

endmodule : debug_enclave_write

// File: sim/test_debug_enclave_write.sv
`timescale 1ns/1ps
module test_debug_enclave_write;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   dbg_write_pkg::mem_wr_s mem_wr;
   dbg_write_pkg::mem_wr_s wr_cap;
   int error_cnt = 0;
   int tests_run = 0;
   int wr_seen = 0;
   logic [31:0] acc_exp, flg_exp, leaf, mode, page, pf_err;
   logic [63:0] src, tgt;

   always #2.5 clk = ~clk;

   debug_enclave_write DUT (
      .clk(clk),
      .rst_n(rst_n),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .mem_wr(mem_wr)
   );

   // store pulses seen on the memory side
   always @(posedge clk) begin
      if (mem_wr.valid === 1'b1) begin
         wr_seen++;
         wr_cap = mem_wr;
      end
   end

   task automatic end_of_test;
      $display("errors %0d comparisons %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test

   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp32

   task automatic cmp64(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp64

   // one Avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] idx,
                      input logic [31:0] wd, output logic [31:0] q);
      int n;
      @(posedge clk);
      avs_address <= idx;
      avs_writedata <= wd;
      avs_read <= ~wr;
      avs_write <= wr;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      if (n >= 100) error_cnt++;
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   function automatic dbg_write_pkg::outcome_e predict(
      input logic [31:0] lf, input logic [31:0] md,
      input logic [31:0] pg, input logic [63:0] ta);
      logic m64;
      logic [7:0] ty;
      m64 = md[0] & md[1];
      ty = pg[15:8];
      if (lf !== dbg_write_pkg::LEAF_SEL) return dbg_write_pkg::OUT_GP;
      if (md[3:2] != 2'h0) return dbg_write_pkg::OUT_GP;
      if (m64 && ta[63:47] != 17'h0 && ta[63:47] != 17'h1FFFF)
         return dbg_write_pkg::OUT_GP;
      if (m64 ? ta[2:0] != 3'h0 : ta[1:0] != 2'h0)
         return dbg_write_pkg::OUT_GP;
      if (pg[1]) return dbg_write_pkg::OUT_PF;
      if (!pg[0]) return dbg_write_pkg::OUT_PF;
      if (pg[18]) return dbg_write_pkg::OUT_GP;
      if (!pg[2]) return dbg_write_pkg::OUT_PF;
      if (!(ty inside {dbg_write_pkg::REGULAR_PAGE_TYPE,
            dbg_write_pkg::THREAD_CONTROL_PAGE_TYPE,
            dbg_write_pkg::SHADOW_STACK_FIRST_TYPE,
            dbg_write_pkg::SHADOW_STACK_REST_TYPE}))
         return dbg_write_pkg::OUT_PF;
      if (pg[16] | pg[17]) return dbg_write_pkg::OUT_NOTDBG;
      if (ty == dbg_write_pkg::THREAD_CONTROL_PAGE_TYPE &&
          (ta[11:0] & dbg_write_pkg::THREAD_CTRL_OFS_MASK) !=
          (dbg_write_pkg::THREAD_CTRL_FLAGS_OFS &
           dbg_write_pkg::THREAD_CTRL_OFS_MASK))
         return dbg_write_pkg::OUT_GP;
      if (!pg[19]) return dbg_write_pkg::OUT_GP;
      return dbg_write_pkg::OUT_OK;
   endfunction : predict

   // hand-made corner cases first, random operands after
   task automatic setup(input int k);
      leaf = dbg_write_pkg::LEAF_SEL;
      mode = 32'h3;
      src = {$urandom, $urandom};
      tgt = 64'h0000_7FFF_1234_5008;
      page = 32'h0008_0105;
      pf_err = $urandom;
      case (k)
         0: leaf = 32'h6;
         1: mode[3:2] = 2'h1;
         2: tgt[52] = 1'b1;
         3: tgt[2] = 1'b1;
         4: page[1] = 1'b1;
         5: page[0] = 1'b0;
         6: page[18] = 1'b1;
         7: page[2] = 1'b0;
         8: page[15:8] = 8'h05;
         9: page[16] = 1'b1;
         10: page[17] = 1'b1;
         11: page[15:8] = dbg_write_pkg::THREAD_CONTROL_PAGE_TYPE;
         12: page[19] = 1'b0;
         13: begin
            page[15:8] = dbg_write_pkg::THREAD_CONTROL_PAGE_TYPE;
            tgt[11:0] = 12'h00C;
            mode = 32'h1;
         end
         14: page[15:8] = dbg_write_pkg::SHADOW_STACK_FIRST_TYPE;
         15: begin
            page[15:8] = dbg_write_pkg::SHADOW_STACK_REST_TYPE;
            mode = 32'h2;
            tgt[2] = 1'b1;
            tgt[52] = 1'b1;
         end
         16: page[22:20] = 3'h7;
         17: page[18:17] = 2'h3;
         18: begin
            mode = 32'h1;
            tgt[1] = 1'b1;
         end
         19: page[19:16] = 4'h1;
         default: begin
            if ($urandom_range(7) == 0) leaf = $urandom;
            mode = $urandom & 32'h3;
            if ($urandom_range(7) == 0) mode[3:2] = 2'($urandom);
            tgt = {($urandom_range(3) == 0) ? $urandom : 32'h0, $urandom};
            if ($urandom_range(3) != 0) tgt[2:0] = 3'h0;
            page = $urandom & 32'h007F_0000;
            page[15:8] = 8'($urandom_range(5));
            page[2:0] = ($urandom_range(3) == 0) ? 3'($urandom) : 3'h5;
            if ($urandom_range(1)) page[18:16] = 3'h0;
            if ($urandom_range(3)) page[19] = 1'b1;
         end
      endcase
   endtask : setup

   task automatic run_op;
      logic [31:0] q;
      logic [31:0] opnd [1:8];
      logic m64;
      logic [1:0] fk;
      dbg_write_pkg::outcome_e o;
      int n;
      m64 = mode[0] & mode[1];
      o = predict(leaf, mode, page, tgt);
      opnd = '{leaf, src[31:0], src[63:32], tgt[31:0], tgt[63:32], mode,
               page, pf_err};
      for (int i = 1; i <= dbg_write_pkg::OPND_LAST; i++) begin
         bus(1'b1, i[3:0], opnd[i], q);
      end
      wr_seen = 0;
      bus(1'b1, dbg_write_pkg::IDX_CTRL, 32'h1, q);
      n = 0;
      do begin
         bus(1'b0, dbg_write_pkg::IDX_CTRL, 32'h0, q);
         n++;
      end while (q[dbg_write_pkg::CTRL_DONE_BIT] !== 1'b1 && n < 20);
      cmp32({31'h0, q[dbg_write_pkg::CTRL_DONE_BIT]}, 32'h1);
      fk = (o == dbg_write_pkg::OUT_GP) ? dbg_write_pkg::FK_GP :
           (o == dbg_write_pkg::OUT_PF) ? dbg_write_pkg::FK_PF :
           dbg_write_pkg::FK_NONE;
      if (o == dbg_write_pkg::OUT_OK) begin
         acc_exp = 32'h0;
         flg_exp = 32'h0;
      end
      if (o == dbg_write_pkg::OUT_NOTDBG) begin
         acc_exp = dbg_write_pkg::PAGE_NOT_DEBUGGABLE_CODE;
         flg_exp = 32'h1 << dbg_write_pkg::FLG_ZF;
      end
      bus(1'b0, dbg_write_pkg::IDX_FAULT, 32'h0, q);
      cmp32(q, {30'h0, fk});
      bus(1'b0, dbg_write_pkg::IDX_FAULT_ERR, 32'h0, q);
      cmp32(q, (fk == dbg_write_pkg::FK_PF) ? pf_err : 32'h0);
      bus(1'b0, dbg_write_pkg::IDX_ACC_LO, 32'h0, q);
      cmp32(q, acc_exp);
      bus(1'b0, dbg_write_pkg::IDX_ACC_HI, 32'h0, q);
      cmp32(q, 32'h0);
      bus(1'b0, dbg_write_pkg::IDX_FLAGS, 32'h0, q);
      cmp32(q, flg_exp);
      cmp32(32'(wr_seen),
            (o == dbg_write_pkg::OUT_OK) ? 32'h1 : 32'h0);
      if (o == dbg_write_pkg::OUT_OK && wr_seen == 1) begin
         cmp64(wr_cap.addr, tgt);
         cmp64(wr_cap.data, m64 ? src : {32'h0, src[31:0]});
         cmp32({24'h0, wr_cap.be}, m64 ? {24'h0, dbg_write_pkg::BE_QWORD} :
               {24'h0, dbg_write_pkg::BE_DWORD});
      end
   endtask : run_op

   initial begin
      logic [31:0] q;
      void'($urandom(70427));
      acc_exp = 32'h0;
      flg_exp = 32'h0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         bus(1'b0, i[3:0], 32'h0, q);
         cmp32(q, 32'h0);
      end
      // read-only and unmapped words must ignore writes
      bus(1'b1, dbg_write_pkg::IDX_ACC_LO, 32'hA5A5_5A5A, q);
      bus(1'b1, 4'hE, 32'h1234_5678, q);
      bus(1'b0, dbg_write_pkg::IDX_ACC_LO, 32'h0, q);
      cmp32(q, 32'h0);
      bus(1'b0, 4'hE, 32'h0, q);
      cmp32(q, 32'h0);
      // partial byte lanes land only where enabled
      bus(1'b1, dbg_write_pkg::IDX_LEAF, 32'hFFFF_FFFF, q);
      avs_byteenable <= 4'h3;
      bus(1'b1, dbg_write_pkg::IDX_LEAF, 32'h0000_0000, q);
      avs_byteenable <= 4'hF;
      bus(1'b0, dbg_write_pkg::IDX_LEAF, 32'h0, q);
      cmp32(q, 32'hFFFF_0000);
      for (int k = 0; k < 80; k++) begin
         setup(k);
         run_op();
      end
      end_of_test();
   end

   initial begin
      #100000;
      error_cnt++;
      end_of_test();
   end
endmodule : test_debug_enclave_write
